// ==== src/slc_pkg.sv ====
// Constants for the sliding-window link control block.
// Assumes a 25 MHz reference clock and a 32-bit Avalon-MM register bus.
`default_nettype none
package slc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ACK_TIME_US = 5000;
  localparam int unsigned RETX_TIME_US = 10000;
  localparam int unsigned CONN_TIME_US = 5000;
  localparam int unsigned ACK_CYC = ACK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RETX_CYC =
    (RETX_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONN_CYC = CONN_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 18;

  localparam logic [1:0] IF_TAG = 2'h2;
  localparam logic [2:0] SF_TAG = 3'h6;
  localparam logic [2:0] UF_TAG = 3'h7;
  localparam logic [1:0] S_RR = 2'h0;
  localparam logic [1:0] S_REJ = 2'h1;
  localparam logic [1:0] S_RNR = 2'h2;
  localparam logic [1:0] S_SREJ = 2'h3;
  localparam logic [4:0] U_LINK_RESET_FRAME = 5'h19;
  localparam logic [4:0] U_UA = 5'h06;
  localparam logic [2:0] DEF_WINDOW = 3'h4;
  localparam logic [2:0] MIN_WINDOW = 3'h2;
  localparam logic [2:0] SEQ_ZERO = 3'h0;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WIN = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_QUEUE = 4'hc;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_SEND = 1;
  localparam int unsigned CTRL_BUSY = 2;
  localparam int unsigned CTRL_SREJ = 3;
  localparam logic CTRL_BUSY_RST = 1'b0;
  localparam logic CTRL_SREJ_RST = 1'b0;

  typedef enum {LK_DOWN, LK_WAIT, LK_UP} slc_link_type;
  typedef enum {TX_NONE, TX_LINK_RESET_FRAME, TX_UA, TX_SREJ, TX_REJ, TX_SRETX, TX_INFO,
    TX_ACK} slc_tx_type;
endpackage : slc_pkg
`default_nettype wire

// ==== src/slc_link.sv ====
// Link control endpoint: frame coding, link reset, window and timers.
// Assumes a framer on ref_clk delivering and taking control bytes.
//
// Added by the designer: the Avalon-MM slave port and the address map.
`default_nettype none
module slc_link #(
  parameter int unsigned ACK_CYCLES = slc_pkg::ACK_CYC,
  parameter int unsigned RETX_CYCLES = slc_pkg::RETX_CYC,
  parameter int unsigned CONN_CYCLES = slc_pkg::CONN_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_ctrl,
  input wire logic [1:0] rx_len,
  input wire logic [7:0] rx_pay0,
  input wire logic [7:0] rx_pay1,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_ctrl,
  output logic [1:0] tx_len,
  output logic [7:0] tx_pay0,
  output logic [7:0] tx_pay1,
  output logic link_up,
  output logic info_accept,
  output logic [2:0] info_seq
);
  localparam int unsigned W = slc_pkg::TMR_W;

  function automatic logic in_win(input logic [2:0] x, input logic [2:0] y,
    input logic [2:0] z);
    if (x <= z) begin
      in_win = (x <= y) && (y < z);
    end else begin
      in_win = (y >= x) || (y < z);
    end
  endfunction : in_win

  slc_pkg::slc_link_type state_r;
  slc_pkg::slc_tx_type sel;
  slc_pkg::slc_tx_type kind_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic busy_r;
  logic loc_srej_r;
  logic [2:0] cap_r;
  logic [2:0] win_r;
  logic srej_ok_r;
  logic peer_busy_r;
  logic [2:0] queue_r;
  logic [2:0] ns_r;
  logic [2:0] top_r;
  logic [2:0] nr_r;
  logic [2:0] dnr_r;
  logic rej_sent_r;
  logic srej_out_r;
  logic buf_valid_r;
  logic pend_link_reset_frame_r;
  logic pend_ua_r;
  logic pend_rej_r;
  logic pend_srej_r;
  logic pend_ack_r;
  logic pend_sretx_r;
  logic [2:0] sretx_num_r;
  logic tx_valid_r;
  logic [7:0] tx_ctrl_r;
  logic [1:0] tx_len_r;
  logic [7:0] tx_pay0_r;
  logic [7:0] tx_pay1_r;
  logic tx_new_r;
  logic info_acc_r;
  logic [2:0] info_seq_r;
  logic ack_run_r;
  logic [W-1:0] ack_cnt_r;
  logic [W-1:0] retx_cnt_r;
  logic [W-1:0] conn_cnt_r;
  logic conn_run_r;

  logic bus_req;
  logic wr_go;
  logic start_req;
  logic send_req;
  logic up;
  logic rx_i;
  logic rx_s;
  logic rx_link_reset_frame;
  logic rx_ua;
  logic [2:0] rx_ns;
  logic [2:0] rx_nr;
  logic [1:0] rx_typ;
  logic [7:0] offer;
  logic too_big;
  logic peer_srej;
  logic take_link_reset_frame;
  logic est;
  logic ack_ok;
  logic in_order;
  logic load;
  logic tx_acc;
  logic acc_info;
  logic acc_nr;
  logic [W-1:0] ack_lim;
  logic ack_fire;
  logic retx_fire;
  logic conn_fire;
  logic rewind;
  logic [2:0] outstanding;

  // Register bus: one wait cycle, answer on the second edge
  assign bus_req = avs_read | avs_write;
  assign wr_go = avs_write && !wait_r;
  assign start_req = wr_go && (avs_address == slc_pkg::REG_CTRL) &&
    avs_writedata[slc_pkg::CTRL_START];
  assign send_req = wr_go && (avs_address == slc_pkg::REG_CTRL) &&
    avs_writedata[slc_pkg::CTRL_SEND];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !(bus_req && wait_r);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0;
    end else if (avs_read && wait_r) begin
      case (avs_address)
        slc_pkg::REG_CTRL: rdata_r <= {28'h0, loc_srej_r, busy_r, 2'h0};
        slc_pkg::REG_WIN: rdata_r <= {29'h0, cap_r};
        slc_pkg::REG_STAT: rdata_r <= {9'h0, top_r, 1'b0, dnr_r, 1'b0, nr_r,
          1'b0, ns_r, 1'b0, peer_busy_r, srej_ok_r, win_r,
          state_r == slc_pkg::LK_WAIT, up};
        slc_pkg::REG_QUEUE: rdata_r <= {29'h0, queue_r};
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= slc_pkg::CTRL_BUSY_RST;
      loc_srej_r <= slc_pkg::CTRL_SREJ_RST;
      cap_r <= slc_pkg::DEF_WINDOW;
    end else if (wr_go && avs_address == slc_pkg::REG_CTRL) begin
      busy_r <= avs_writedata[slc_pkg::CTRL_BUSY];
      loc_srej_r <= avs_writedata[slc_pkg::CTRL_SREJ];
    end else if (wr_go && avs_address == slc_pkg::REG_WIN) begin
      if (avs_writedata[2:0] >= slc_pkg::MIN_WINDOW &&
          avs_writedata[2:0] <= slc_pkg::DEF_WINDOW) begin
        cap_r <= avs_writedata[2:0];
      end
    end
  end

  // Received frame decode
  assign up = state_r == slc_pkg::LK_UP;
  assign rx_ns = rx_ctrl[5:3];
  assign rx_nr = rx_ctrl[2:0];
  assign rx_typ = rx_ctrl[4:3];
  assign rx_i = rx_valid && up && rx_ctrl[7:6] == slc_pkg::IF_TAG;
  assign rx_s = rx_valid && up && rx_ctrl[7:5] == slc_pkg::SF_TAG;
  assign rx_link_reset_frame = rx_valid && rx_ctrl[7:5] == slc_pkg::UF_TAG &&
    rx_ctrl[4:0] == slc_pkg::U_LINK_RESET_FRAME;
  assign rx_ua = rx_valid && state_r == slc_pkg::LK_WAIT &&
    rx_ctrl[7:5] == slc_pkg::UF_TAG && rx_ctrl[4:0] == slc_pkg::U_UA;
  assign offer = (rx_len != 2'h0) ? rx_pay0 : {5'h0, slc_pkg::DEF_WINDOW};
  assign too_big = offer > {5'h0, cap_r};
  assign peer_srej = (rx_len == 2'h2) && rx_pay1[0];
  assign take_link_reset_frame = rx_link_reset_frame && !too_big && offer >= 8'h2;
  assign est = take_link_reset_frame || (rx_ua && !rx_link_reset_frame);
  assign ack_ok = (rx_i || (rx_s && rx_typ != slc_pkg::S_SREJ)) &&
    in_win(dnr_r, rx_nr, 3'(top_r + 3'h1));
  assign in_order = rx_i && rx_ns == nr_r;
  assign outstanding = 3'(top_r - dnr_r);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= slc_pkg::LK_DOWN;
      win_r <= slc_pkg::DEF_WINDOW;
      srej_ok_r <= 1'b0;
    end else if (take_link_reset_frame) begin
      state_r <= slc_pkg::LK_UP;
      win_r <= offer[2:0];
      srej_ok_r <= peer_srej && loc_srej_r;
    end else if (rx_link_reset_frame || start_req) begin
      state_r <= slc_pkg::LK_WAIT;
    end else if (rx_ua) begin
      state_r <= slc_pkg::LK_UP;
      win_r <= cap_r;
      srej_ok_r <= 1'b0;
    end
  end

  // Transmit choice: link control first, then rejects, then data, then acknowledge
  always_comb begin
    sel = slc_pkg::TX_NONE;
    if (pend_link_reset_frame_r) begin
      sel = slc_pkg::TX_LINK_RESET_FRAME;
    end else if (pend_ua_r) begin
      sel = slc_pkg::TX_UA;
    end else if (!up || rx_link_reset_frame || start_req) begin
      sel = slc_pkg::TX_NONE;
    end else if (pend_srej_r) begin
      sel = slc_pkg::TX_SREJ;
    end else if (pend_rej_r) begin
      sel = slc_pkg::TX_REJ;
    end else if (pend_sretx_r && !peer_busy_r) begin
      sel = slc_pkg::TX_SRETX;
    end else if (!peer_busy_r && (ns_r != top_r ||
        (queue_r != 3'h0 && outstanding < win_r))) begin
      sel = slc_pkg::TX_INFO;
    end else if (pend_ack_r) begin
      sel = slc_pkg::TX_ACK;
    end
  end

  assign load = !tx_valid_r && sel != slc_pkg::TX_NONE;
  assign tx_acc = tx_valid_r && tx_ready;
  assign acc_info = tx_acc && (kind_r == slc_pkg::TX_INFO ||
    kind_r == slc_pkg::TX_SRETX);
  assign acc_nr = tx_acc && kind_r != slc_pkg::TX_LINK_RESET_FRAME &&
    kind_r != slc_pkg::TX_UA;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid_r <= 1'b0;
      tx_ctrl_r <= 8'h0;
      tx_len_r <= 2'h0;
      tx_pay0_r <= 8'h0;
      tx_pay1_r <= 8'h0;
      tx_new_r <= 1'b0;
      kind_r <= slc_pkg::TX_NONE;
    end else if (load) begin
      tx_valid_r <= 1'b1;
      kind_r <= sel;
      tx_len_r <= 2'h0;
      tx_pay0_r <= 8'h0;
      tx_pay1_r <= 8'h0;
      tx_new_r <= ns_r == top_r;
      case (sel)
        slc_pkg::TX_LINK_RESET_FRAME: begin
          tx_ctrl_r <= {slc_pkg::UF_TAG, slc_pkg::U_LINK_RESET_FRAME};
          tx_len_r <= 2'h2;
          tx_pay0_r <= {5'h0, cap_r};
          tx_pay1_r <= {7'h0, loc_srej_r};
        end
        slc_pkg::TX_UA: tx_ctrl_r <= {slc_pkg::UF_TAG, slc_pkg::U_UA};
        slc_pkg::TX_SREJ:
          tx_ctrl_r <= {slc_pkg::SF_TAG, slc_pkg::S_SREJ, nr_r};
        slc_pkg::TX_REJ:
          tx_ctrl_r <= {slc_pkg::SF_TAG, slc_pkg::S_REJ, nr_r};
        slc_pkg::TX_SRETX: begin
          tx_ctrl_r <= {slc_pkg::IF_TAG, sretx_num_r, nr_r};
          tx_new_r <= 1'b0;
        end
        slc_pkg::TX_INFO:
          tx_ctrl_r <= {slc_pkg::IF_TAG, ns_r, nr_r};
        slc_pkg::TX_ACK: tx_ctrl_r <= {slc_pkg::SF_TAG,
          busy_r ? slc_pkg::S_RNR : slc_pkg::S_RR, nr_r};
        default: tx_valid_r <= 1'b0;
      endcase
    end else if (tx_acc) begin
      tx_valid_r <= 1'b0;
    end
  end

  // Pending frame requests; a new cause beats the clear on load
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_link_reset_frame_r <= 1'b0;
      pend_ua_r <= 1'b0;
      pend_rej_r <= 1'b0;
      pend_srej_r <= 1'b0;
      pend_ack_r <= 1'b0;
      pend_sretx_r <= 1'b0;
      sretx_num_r <= slc_pkg::SEQ_ZERO;
    end else begin
      if (load) begin
        case (sel)
          slc_pkg::TX_LINK_RESET_FRAME: pend_link_reset_frame_r <= 1'b0;
          slc_pkg::TX_UA: pend_ua_r <= 1'b0;
          slc_pkg::TX_SREJ: pend_srej_r <= 1'b0;
          slc_pkg::TX_REJ: pend_rej_r <= 1'b0;
          slc_pkg::TX_SRETX: pend_sretx_r <= 1'b0;
          default: pend_ack_r <= 1'b0;
        endcase
      end
      if (rx_link_reset_frame || start_req) begin
        pend_ua_r <= 1'b0;
        pend_rej_r <= 1'b0;
        pend_srej_r <= 1'b0;
        pend_ack_r <= 1'b0;
        pend_sretx_r <= 1'b0;
      end
      if (start_req || (rx_link_reset_frame && !take_link_reset_frame) || conn_fire) begin
        pend_link_reset_frame_r <= 1'b1;
      end
      if (take_link_reset_frame) begin
        pend_ua_r <= 1'b1;
        pend_link_reset_frame_r <= 1'b0;
      end
      if (rx_ua) begin
        pend_link_reset_frame_r <= 1'b0;
      end
      if (ack_fire) begin
        pend_ack_r <= 1'b1;
      end
      if (rx_i && !in_order) begin
        if (srej_ok_r && rx_ns == 3'(nr_r + 3'h1) && !srej_out_r &&
            !buf_valid_r) begin
          pend_srej_r <= 1'b1;
        end else if (!rej_sent_r) begin
          pend_rej_r <= 1'b1;
        end
      end
      if (rx_s && rx_typ == slc_pkg::S_SREJ && srej_ok_r) begin
        pend_sretx_r <= 1'b1;
        sretx_num_r <= rx_nr;
      end
    end
  end

  // Sequence variables and receive bookkeeping
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ns_r <= slc_pkg::SEQ_ZERO;
      top_r <= slc_pkg::SEQ_ZERO;
      nr_r <= slc_pkg::SEQ_ZERO;
      dnr_r <= slc_pkg::SEQ_ZERO;
      rej_sent_r <= 1'b0;
      srej_out_r <= 1'b0;
      buf_valid_r <= 1'b0;
      peer_busy_r <= 1'b0;
    end else if (est) begin
      ns_r <= slc_pkg::SEQ_ZERO;
      top_r <= slc_pkg::SEQ_ZERO;
      nr_r <= slc_pkg::SEQ_ZERO;
      dnr_r <= slc_pkg::SEQ_ZERO;
      rej_sent_r <= 1'b0;
      srej_out_r <= 1'b0;
      buf_valid_r <= 1'b0;
      peer_busy_r <= 1'b0;
    end else begin
      if (acc_info && kind_r == slc_pkg::TX_INFO) begin
        ns_r <= 3'(tx_ctrl_r[5:3] + 3'h1);
        if (tx_new_r) begin
          top_r <= 3'(tx_ctrl_r[5:3] + 3'h1);
        end
      end
      if (ack_ok) begin
        dnr_r <= rx_nr;
      end
      if (rx_s) begin
        peer_busy_r <= rx_typ == slc_pkg::S_RNR;
      end
      if (ack_ok && rx_s && rx_typ == slc_pkg::S_REJ) begin
        ns_r <= rx_nr;
      end else if (retx_fire) begin
        ns_r <= dnr_r;
      end
      if (in_order) begin
        rej_sent_r <= 1'b0;
        if (buf_valid_r && srej_out_r) begin
          nr_r <= 3'(nr_r + 3'h2);
          buf_valid_r <= 1'b0;
          srej_out_r <= 1'b0;
        end else begin
          nr_r <= 3'(nr_r + 3'h1);
        end
      end else if (rx_i) begin
        if (srej_ok_r && rx_ns == 3'(nr_r + 3'h1) && !srej_out_r &&
            !buf_valid_r) begin
          srej_out_r <= 1'b1;
          buf_valid_r <= 1'b1;
        end else begin
          rej_sent_r <= 1'b1;
        end
      end
    end
  end

  // Queue of information frames requested by software
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      queue_r <= 3'h0;
    end else if (start_req || rx_link_reset_frame) begin
      queue_r <= 3'h0;
    end else begin
      case ({send_req && queue_r != 3'h7, acc_info && tx_new_r &&
          kind_r == slc_pkg::TX_INFO})
        2'b10: queue_r <= 3'(queue_r + 3'h1);
        2'b01: queue_r <= 3'(queue_r - 3'h1);
        default: queue_r <= queue_r;
      endcase
    end
  end

  // Acknowledge, retransmit and connection timers
  assign ack_lim = W'((ACK_CYCLES / 4) * win_r);
  assign ack_fire = ack_run_r && ack_cnt_r >= ack_lim;
  assign retx_fire = up && dnr_r != top_r && retx_cnt_r >= W'(RETX_CYCLES);
  assign conn_fire = conn_run_r && conn_cnt_r >= W'(CONN_CYCLES);
  assign rewind = acc_info || ack_ok || retx_fire;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_run_r <= 1'b0;
      ack_cnt_r <= '0;
    end else if (est || acc_nr || ack_fire) begin
      ack_run_r <= 1'b0;
      ack_cnt_r <= '0;
    end else if (in_order) begin
      ack_run_r <= 1'b1;
    end else if (ack_run_r) begin
      ack_cnt_r <= W'(ack_cnt_r + 1'b1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      retx_cnt_r <= '0;
    end else if (rewind || est || dnr_r == top_r) begin
      retx_cnt_r <= '0;
    end else begin
      retx_cnt_r <= W'(retx_cnt_r + 1'b1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conn_run_r <= 1'b0;
      conn_cnt_r <= '0;
    end else if (tx_acc && kind_r == slc_pkg::TX_LINK_RESET_FRAME) begin
      conn_run_r <= 1'b1;
      conn_cnt_r <= '0;
    end else if (rx_link_reset_frame || rx_ua || conn_fire || up) begin
      conn_run_r <= 1'b0;
      conn_cnt_r <= '0;
    end else if (conn_run_r) begin
      conn_cnt_r <= W'(conn_cnt_r + 1'b1);
    end
  end

  // Delivery strobe for an in-sequence information frame
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      info_acc_r <= 1'b0;
      info_seq_r <= slc_pkg::SEQ_ZERO;
    end else begin
      info_acc_r <= in_order && !start_req;
      info_seq_r <= rx_ns;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign tx_valid = tx_valid_r;
  assign tx_ctrl = tx_ctrl_r;
  assign tx_len = tx_len_r;
  assign tx_pay0 = tx_pay0_r;
  assign tx_pay1 = tx_pay1_r;
  assign info_accept = info_acc_r;
  assign info_seq = info_seq_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_up <= 1'b0;
    end else begin
      link_up <= est || (up && !rx_link_reset_frame && !start_req);
    end
  end
endmodule : slc_link
`default_nettype wire

// ==== testbench/slc_link_checker.sv ====
// Checker for the link control block: bus answer, frame coding, link.
// Assumes it is bound to slc_link and sees only its ports.
`default_nettype none
module slc_link_checker #(
  parameter int unsigned ACK_CYCLES = 64,
  parameter int unsigned RETX_CYCLES = 200,
  parameter int unsigned CONN_CYCLES = 100
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_ctrl,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_ctrl,
  input wire logic [1:0] tx_len,
  input wire logic [7:0] tx_pay0,
  input wire logic [7:0] tx_pay1,
  input wire logic link_up,
  input wire logic info_accept
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  bus_answer_a: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("bus not answered");
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=>
    avs_waitrequest) else $error("waitrequest low too long");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_ctrl) && $stable(tx_len) && $stable(tx_pay0))
    else $error("offered frame changed");
  tx_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("no idle cycle after frame");
  ctrl_top_a: assert property (tx_valid |-> tx_ctrl[7])
    else $error("control byte top bit low");
  unnum_kind_a: assert property (tx_valid &&
    tx_ctrl[7:5] == slc_pkg::UF_TAG |->
    (tx_ctrl[4:0] == slc_pkg::U_LINK_RESET_FRAME && tx_len == 2'h2) ||
    (tx_ctrl[4:0] == slc_pkg::U_UA && tx_len == 2'h0))
    else $error("bad unnumbered frame");
  sup_empty_a: assert property (tx_valid &&
    tx_ctrl[7:5] == slc_pkg::SF_TAG |-> tx_len == 2'h0)
    else $error("supervisory frame with payload");
  link_reset_frame_pay_a: assert property (tx_valid &&
    tx_ctrl == {slc_pkg::UF_TAG, slc_pkg::U_LINK_RESET_FRAME} |->
    tx_pay0 inside {[8'h2:8'h4]} && tx_pay1[7:1] == 7'h0)
    else $error("bad link reset payload");
  down_quiet_a: assert property ($rose(tx_valid) && !link_up |->
    tx_ctrl[7:5] == slc_pkg::UF_TAG) else $error("numbered frame while down");
  accept_up_a: assert property (info_accept |-> link_up)
    else $error("frame accepted while down");
  link_rise_a: assert property ($rose(link_up) |->
    $past(rx_valid) && $past(rx_ctrl[7:5]) == slc_pkg::UF_TAG)
    else $error("link up without unnumbered frame");
endmodule : slc_link_checker
bind slc_link slc_link_checker #(
  .ACK_CYCLES(ACK_CYCLES),
  .RETX_CYCLES(RETX_CYCLES),
  .CONN_CYCLES(CONN_CYCLES)
) u_chk (
  .ref_clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest,
  .rx_valid, .rx_ctrl, .tx_valid, .tx_ready, .tx_ctrl, .tx_len,
  .tx_pay0, .tx_pay1, .link_up, .info_accept
);
`default_nettype wire

// ==== testbench/slc_peer.sv ====
// Peer endpoint model: takes offered frames, sends frames on command.
// Assumes the bench pops got and calls send_frame from one thread.
`default_nettype none
module slc_peer (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_ctrl,
  input wire logic [1:0] tx_len,
  input wire logic [7:0] tx_pay0,
  input wire logic [7:0] tx_pay1,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_ctrl,
  output logic [1:0] rx_len,
  output logic [7:0] rx_pay0,
  output logic [7:0] rx_pay1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  logic [31:0] cyc;
  logic [57:0] got[$];
  initial begin
    ph = 2'h0;
    cyc = 32'h0;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_ctrl = 8'h0;
    rx_len = 2'h0;
    rx_pay0 = 8'h0;
    rx_pay1 = 8'h0;
  end
  // Ready every cycle, or one in four when slow
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    cyc <= cyc + 32'h1;
    tx_ready <= !slow || ph == 2'h3;
    if (tx_valid && tx_ready)
      got.push_back({cyc, tx_pay1, tx_pay0, tx_len, tx_ctrl});
  end
  // One-cycle strobe, then the lines show the inverse
  task automatic send_frame(input logic [7:0] c, input logic [1:0] l,
    input logic [7:0] p0, input logic [7:0] p1);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_ctrl <= c;
    rx_len <= l;
    rx_pay0 <= p0;
    rx_pay1 <= p1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_ctrl <= ~c;
    rx_len <= ~l;
    rx_pay0 <= ~p0;
    rx_pay1 <= ~p1;
  endtask : send_frame
endmodule : slc_peer
`default_nettype wire

// ==== testbench/slc_link_tb_top.sv ====
// Testbench for the link control block with a peer model.
// Assumes small timer parameters and a 25 MHz clock.
`default_nettype none
module slc_link_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned ACK = 64;
  localparam int unsigned RETX = 200;
  localparam int unsigned CONN = 100;
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, slow;
  logic rx_valid, tx_valid, tx_ready, link_up, info_accept;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, f_cyc, c0;
  logic [7:0] rx_ctrl, rx_pay0, rx_pay1, tx_ctrl, tx_pay0, tx_pay1;
  logic [1:0] rx_len, tx_len;
  logic [2:0] info_seq, last_seq;
  int err_count, n_compared, n_acc;
  slc_link #(.ACK_CYCLES(ACK), .RETX_CYCLES(RETX), .CONN_CYCLES(CONN))
    dut (.*);
  slc_peer peer (.*);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (info_accept === 1'b1) begin
    n_acc <= n_acc + 1;
    last_seq <= info_seq;
  end
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 50) begin
      err_count++;
      final_report();
    end
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask : chk_reg
  // Skip 1 drops supervisory frames, skip 2 all but unnumbered
  task automatic frame(input int skip, input logic [7:0] c,
    input logic [1:0] l, input logic [7:0] p0, input logic [7:0] p1);
    logic [57:0] e;
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge ref_clk);
      if (peer.got.size() > 0) begin
        e = peer.got.pop_front();
        if (!(skip == 1 && e[7:5] == 3'h6 || skip == 2 && e[7:5] != 3'h7))
          break;
      end
    end
    if (i == 4000) begin
      err_count++;
      final_report();
    end
    f_cyc = e[57:26];
    cmp(32'(e[7:0]), 32'(c));
    cmp(32'(e[9:8]), 32'(l));
    if (l == 2'h2) begin
      cmp(32'(e[17:10]), 32'(p0));
      cmp(32'(e[25:18]), 32'(p1));
    end
  endtask : frame
  task automatic t_regs();
    chk_reg(slc_pkg::REG_CTRL, 32'h0);
    chk_reg(slc_pkg::REG_WIN, 32'h4);
    wr(slc_pkg::REG_WIN, 32'h5);
    chk_reg(slc_pkg::REG_WIN, 32'h4);
    chk_reg(4'h2, 32'h0);
    bus(1'b0, slc_pkg::REG_STAT, 32'h0);
    cmp(32'(rd[1:0]), 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_start();
    wr(slc_pkg::REG_CTRL, 32'h1);
    frame(0, 8'hf9, 2'h2, 8'h4, 8'h0);
    peer.send_frame(8'h80, 2'h0, 8'h0, 8'h0);
    peer.send_frame(8'he6, 2'h0, 8'h0, 8'h0);
    repeat (3) @(posedge ref_clk);
    cmp(32'(link_up), 32'h1);
    cmp(32'(n_acc), 32'h0);
    chk_reg(slc_pkg::REG_STAT, 32'h11);
    $display("t_start done");
  endtask : t_start
  task automatic t_rx();
    peer.send_frame(8'h80, 2'h0, 8'h0, 8'h0);
    peer.send_frame(8'h88, 2'h0, 8'h0, 8'h0);
    c0 = peer.cyc;
    frame(0, 8'hc2, 2'h0, 8'h0, 8'h0);
    cmp(32'(f_cyc - c0 < ACK + 8), 32'h1);
    cmp(32'(n_acc), 32'h2);
    cmp(32'(last_seq), 32'h1);
    peer.send_frame(8'ha8, 2'h0, 8'h0, 8'h0);
    frame(0, 8'hca, 2'h0, 8'h0, 8'h0);
    cmp(32'(n_acc), 32'h2);
    $display("t_rx done");
  endtask : t_rx
  task automatic t_busy();
    wr(slc_pkg::REG_CTRL, 32'h4);
    peer.send_frame(8'h90, 2'h0, 8'h0, 8'h0);
    frame(0, 8'hd3, 2'h0, 8'h0, 8'h0);
    cmp(32'(last_seq), 32'h2);
    wr(slc_pkg::REG_CTRL, 32'h0);
    $display("t_busy done");
  endtask : t_busy
  task automatic t_send();
    int i;
    slow <= 1'b1;
    repeat (5) wr(slc_pkg::REG_CTRL, 32'h2);
    for (i = 0; i < 4; i++)
      frame(1, {2'h2, 3'(i), 3'h3}, 2'h0, 8'h0, 8'h0);
    c0 = f_cyc;
    repeat (60) @(posedge ref_clk);
    chk_reg(slc_pkg::REG_QUEUE, 32'h1);
    frame(1, 8'h83, 2'h0, 8'h0, 8'h0);
    cmp(32'(f_cyc - c0 >= RETX), 32'h1);
    slow <= 1'b0;
    $display("t_send done");
  endtask : t_send
  task automatic t_neg();
    wr(slc_pkg::REG_WIN, 32'h2);
    peer.send_frame(8'hf9, 2'h0, 8'h0, 8'h0);
    frame(2, 8'hf9, 2'h2, 8'h2, 8'h0);
    chk_reg(slc_pkg::REG_QUEUE, 32'h0);
    peer.send_frame(8'he6, 2'h0, 8'h0, 8'h0);
    repeat (3) @(posedge ref_clk);
    chk_reg(slc_pkg::REG_STAT, 32'h9);
    $display("t_neg done");
  endtask : t_neg
  task automatic t_srej();
    wr(slc_pkg::REG_WIN, 32'h4);
    wr(slc_pkg::REG_CTRL, 32'h8);
    chk_reg(slc_pkg::REG_STAT, 32'h9);
    peer.send_frame(8'hf9, 2'h2, 8'h3, 8'h1);
    frame(2, 8'he6, 2'h0, 8'h0, 8'h0);
    chk_reg(slc_pkg::REG_STAT, 32'h2d);
    peer.send_frame(8'h88, 2'h0, 8'h0, 8'h0);
    frame(0, 8'hd8, 2'h0, 8'h0, 8'h0);
    $display("t_srej done");
  endtask : t_srej
  task automatic t_sretx();
    wr(slc_pkg::REG_CTRL, 32'ha);
    frame(1, 8'h80, 2'h0, 8'h0, 8'h0);
    peer.send_frame(8'hd8, 2'h0, 8'h0, 8'h0);
    c0 = peer.cyc;
    frame(1, 8'h80, 2'h0, 8'h0, 8'h0);
    cmp(32'(f_cyc - c0 < 16), 32'h1);
    $display("t_sretx done");
  endtask : t_sretx
  task automatic t_conn();
    wr(slc_pkg::REG_CTRL, 32'h9);
    frame(2, 8'hf9, 2'h2, 8'h4, 8'h1);
    c0 = f_cyc;
    frame(2, 8'hf9, 2'h2, 8'h4, 8'h1);
    cmp(32'(f_cyc - c0 <= CONN + 8), 32'h1);
    $display("t_conn done");
  endtask : t_conn
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    slow = 1'b0;
    err_count = 0;
    n_compared = 0;
    n_acc = 0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_start();
    t_rx();
    t_busy();
    t_send();
    t_neg();
    t_srej();
    t_sretx();
    t_conn();
    final_report();
  end
endmodule : slc_link_tb_top
`default_nettype wire
